// *** design/hsp_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// Hardware serial port: setup, transmit with optional break, command and
// background receive. Scratchpad writes leave as a strobe with address.
module hsp_top
#(
    parameter int unsigned TIMEOUT_MS_MAX = 65535 // Range-checked only; rxcmd_tmo_ms_in is not limited by it.
)
(
    input  wire logic                  clk_in,          // System clock.
    input  wire logic                  rst_n_in,        // Asynchronous reset.
    input  wire logic                  setup_in,        // Setup command pulse.
    input  wire hsp_pkg::hsp_setup_type setup_cfg_in,   // Setup arguments.
    input  wire logic                  tx_valid_in,     // Transmit byte offered.
    input  wire logic [7:0]            tx_data_in,      // Transmit byte.
    input  wire logic                  tx_break_in,     // Break before this byte.
    output logic                       tx_ready_out,    // Byte taken this cycle.
    input  wire logic                  rxcmd_start_in,  // Receive command pulse.
    input  wire logic [7:0]            rxcmd_count_in,  // Bytes wanted.
    input  wire logic [15:0]           rxcmd_tmo_ms_in, // Timeout, zero is none.
    output logic                       rxcmd_busy_out,  // Receive command running.
    output logic                       rxcmd_done_out,  // Pulse, count reached.
    output logic                       rxcmd_tmo_out,   // Pulse, timed out.
    output logic                       sp_we_out,       // Scratchpad write pulse.
    output logic [7:0]                 sp_addr_out,     // Scratchpad address.
    output logic [7:0]                 sp_data_out,     // Scratchpad data.
    input  wire logic                  flag_clr_in,     // Clear received flag.
    output logic                       rx_flag_out,     // Received-byte flag.
    output logic [7:0]                 bg_ptr_out,      // Background pointer.
    input  wire logic                  rx_pin_in,       // Serial input pin.
    output logic                       tx_pin_out,      // Serial output pin.
    output logic                       tx_pin_oe_out,   // Pin driven by port.
    output logic                       pins_owned_out   // Pins dedicated.
);
    initial
    begin
        if (TIMEOUT_MS_MAX == 0 || TIMEOUT_MS_MAX > 65535)
            $error("TIMEOUT_MS_MAX out of range");
    end

    hsp_pkg::hsp_setup_type cfg_r;          // Held configuration.
    logic [2:0]             sync_r;         // Input synchroniser chain.
    logic                   line_r;         // Debounced line level.
    logic                   rx_valid;       // Framer byte pulse.
    logic [7:0]             rx_data;        // Framer byte.
    logic [17:0]            bit_len;        // Clocks per bit.
    hsp_pkg::hsp_tx_state_type tx_state_r;  // Transmitter state.
    logic [17:0]            tx_tick_r;      // Transmit bit timer.
    logic [3:0]             tx_bit_r;       // Bit counter.
    logic [9:0]             tx_shift_r;     // Frame shifter incl. start/stop.
    logic                   tx_level_r;     // True-polarity line level.
    logic [7:0]             rxc_left_r;     // Bytes still wanted.
    logic [7:0]             rxc_addr_r;     // Command store address.
    logic [15:0]            ms_left_r;      // Milliseconds left.
    logic [31:0]            ms_tick_r;      // Cycles inside a millisecond.
    logic                   tmo_on_r;       // Timeout armed.

    // Mode bit decode used in several places.
    function automatic logic mode_bit(input logic [1:0] m, input int unsigned b);
        mode_bit = m[b];
    endfunction : mode_bit

    assign bit_len = ({2'b00, cfg_r.divisor} + 18'h00001) << hsp_pkg::BRG_SHIFT; // RL14

    // Setup latches the whole configuration; off clears enable.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cfg_r          <= '0;
            pins_owned_out <= 1'b0;
        end
        else if (setup_in)
        begin
            // Any preset divisor fits the sixteen-bit word as given.
            cfg_r          <= setup_cfg_in; // RL5
            pins_owned_out <= setup_cfg_in.enable; // RL6 RL17
        end
    end

    // Three stages; a change counts once the last two agree. No inversion.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sync_r <= 3'b111;
            line_r <= 1'b1;
        end
        else
        begin
            sync_r <= {sync_r[1:0], rx_pin_in};
            if (sync_r[2] == sync_r[1])
            begin
                line_r <= sync_r[2]; // RL10
            end
        end
    end

    hsp_rx_frame u_frame
    (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n_in),
        .enable_in  (cfg_r.enable),
        .divisor_in (cfg_r.divisor),
        .line_in    (line_r),
        .valid_out  (rx_valid),
        .data_out   (rx_data)
    );

    // Transmitter: break first when asked, then one 8N1 frame per byte.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            tx_state_r   <= hsp_pkg::HSP_TX_IDLE;
            tx_tick_r    <= 18'h00000;
            tx_bit_r     <= 4'h0;
            tx_shift_r   <= 10'h3FF;
            tx_level_r   <= 1'b1;
            tx_ready_out <= 1'b0;
        end
        else
        begin
            tx_ready_out <= 1'b0;
            case (tx_state_r)
                hsp_pkg::HSP_TX_IDLE:
                begin
                    tx_level_r <= 1'b1;
                    // Bytes offered before setup are held off, not lost.
                    if (tx_valid_in && cfg_r.enable && !tx_ready_out) // RL4
                    begin
                        tx_ready_out <= 1'b1; // RL3
                        tx_shift_r   <= {1'b1, tx_data_in, 1'b0}; // RL1
                        tx_tick_r    <= bit_len - 18'h00001;
                        if (tx_break_in)
                        begin
                            tx_state_r <= hsp_pkg::HSP_TX_BREAK; // RL2
                            tx_bit_r   <= 4'(hsp_pkg::BREAK_BITS - 1);
                            tx_level_r <= 1'b0;
                        end
                        else
                        begin
                            tx_state_r <= hsp_pkg::HSP_TX_FRAME;
                            tx_bit_r   <= 4'(hsp_pkg::DATA_BITS + 1);
                            tx_level_r <= 1'b0;
                        end
                    end
                end
                hsp_pkg::HSP_TX_BREAK, hsp_pkg::HSP_TX_FRAME:
                begin
                    if (!cfg_r.enable)
                    begin
                        tx_state_r <= hsp_pkg::HSP_TX_IDLE;
                    end
                    else if (tx_tick_r != 18'h00000)
                    begin
                        tx_tick_r <= tx_tick_r - 18'h00001;
                    end
                    else if (tx_bit_r == 4'h0)
                    begin
                        if (tx_state_r == hsp_pkg::HSP_TX_BREAK)
                        begin
                            // One high bit time separates break and frame.
                            tx_state_r <= hsp_pkg::HSP_TX_FRAME;
                            tx_bit_r   <= 4'(hsp_pkg::DATA_BITS + 2);
                            tx_shift_r <= {tx_shift_r[8:0], 1'b1};
                            tx_level_r <= 1'b1;
                            tx_tick_r  <= bit_len - 18'h00001;
                        end
                        else
                        begin
                            tx_state_r <= hsp_pkg::HSP_TX_IDLE;
                        end
                    end
                    else
                    begin
                        tx_tick_r <= bit_len - 18'h00001;
                        tx_bit_r  <= tx_bit_r - 4'h1;
                        if (tx_state_r == hsp_pkg::HSP_TX_FRAME)
                        begin
                            tx_shift_r <= {1'b1, tx_shift_r[9:1]};
                            tx_level_r <= tx_shift_r[1];
                        end
                    end
                end
                default:
                begin
                    tx_state_r <= hsp_pkg::HSP_TX_IDLE;
                end
            endcase
        end
    end

    // Output pin with polarity; released when the port is off.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            tx_pin_out    <= 1'b1;
            tx_pin_oe_out <= 1'b0;
        end
        else
        begin
            tx_pin_out    <= tx_level_r ^ mode_bit(cfg_r.mode, hsp_pkg::MODE_INV_BIT); // RL9
            tx_pin_oe_out <= cfg_r.enable; // RL17
        end
    end

    // Receive command: counts bytes and the millisecond timeout.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rxcmd_busy_out <= 1'b0;
            rxcmd_done_out <= 1'b0;
            rxcmd_tmo_out  <= 1'b0;
            rxc_left_r     <= 8'h00;
            rxc_addr_r     <= 8'h00;
            ms_left_r      <= 16'h0000;
            ms_tick_r      <= 32'h00000000;
            tmo_on_r       <= 1'b0;
        end
        else
        begin
            rxcmd_done_out <= 1'b0;
            rxcmd_tmo_out  <= 1'b0;
            if (rxcmd_start_in && cfg_r.enable && !rxcmd_busy_out)
            begin
                rxcmd_busy_out <= (rxcmd_count_in != 8'h00);
                rxcmd_done_out <= (rxcmd_count_in == 8'h00);
                rxc_left_r     <= rxcmd_count_in;
                rxc_addr_r     <= 8'h00;
                ms_left_r      <= rxcmd_tmo_ms_in;
                ms_tick_r      <= 32'(hsp_pkg::CYC_PER_MS - 1);
                tmo_on_r       <= (rxcmd_tmo_ms_in != 16'h0000);
            end
            else if (rxcmd_busy_out)
            begin
                if (rx_valid && !mode_bit(cfg_r.mode, hsp_pkg::MODE_BG_BIT)) // RL8 RL15
                begin
                    rxc_addr_r <= rxc_addr_r + 8'h01;
                    rxc_left_r <= rxc_left_r - 8'h01;
                    if (rxc_left_r == 8'h01)
                    begin
                        rxcmd_busy_out <= 1'b0;
                        rxcmd_done_out <= 1'b1;
                    end
                end
                else if (tmo_on_r)
                begin
                    if (ms_tick_r != 32'h00000000)
                    begin
                        ms_tick_r <= ms_tick_r - 32'h00000001;
                    end
                    else if (ms_left_r == 16'h0001)
                    begin
                        rxcmd_busy_out <= 1'b0; // RL16
                        rxcmd_tmo_out  <= 1'b1; // RL16
                    end
                    else
                    begin
                        ms_left_r <= ms_left_r - 16'h0001;
                        ms_tick_r <= 32'(hsp_pkg::CYC_PER_MS - 1);
                    end
                end
            end
        end
    end

    // Scratchpad writes from background mode or from a running command.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sp_we_out   <= 1'b0;
            sp_addr_out <= 8'h00;
            sp_data_out <= 8'h00;
            bg_ptr_out  <= hsp_pkg::PTR_RESET;
        end
        else
        begin
            sp_we_out <= 1'b0;
            if (setup_in)
            begin
                bg_ptr_out <= hsp_pkg::PTR_RESET; // RL11
            end
            else if (rx_valid && mode_bit(cfg_r.mode, hsp_pkg::MODE_BG_BIT)) // RL7
            begin
                sp_we_out   <= 1'b1; // RL12
                sp_addr_out <= bg_ptr_out;
                sp_data_out <= rx_data;
                bg_ptr_out  <= bg_ptr_out + 8'h01; // RL12
            end
            else if (rx_valid && rxcmd_busy_out) // RL15
            begin
                sp_we_out   <= 1'b1;
                sp_addr_out <= rxc_addr_r;
                sp_data_out <= rx_data;
            end
        end
    end

    // Received flag: a new background byte wins over a clear in the same cycle.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rx_flag_out <= 1'b0;
        end
        else if (rx_valid && mode_bit(cfg_r.mode, hsp_pkg::MODE_BG_BIT) && !setup_in)
        begin
            rx_flag_out <= 1'b1; // RL12
        end
        else if (flag_clr_in)
        begin
            rx_flag_out <= 1'b0; // RL13
        end
    end
endmodule : hsp_top
`default_nettype wire

// *** design/hsp_pkg.sv ***
// Function
// RL1 - Frames are 8 data, no parity, 1 stop.
// RL2 - Break argument one sends break before data.
// RL3 - Each byte sent as one character, in order.
// RL4 - Software runs setup before transmit or receive.
// RL5 - Predefined divisors 300 to 115200 baud supported.
// RL6 - Setup dedicates one transmit and one receive pin.
// RL7 - Mode bit 0 set stores bytes in background.
// RL8 - Mode bit 0 clear: receive command only.
// RL9 - Mode bit 1 selects inverted transmit output.
// RL10 - Receive input always taken with true polarity.
// RL11 - Setup resets background write pointer to zero.
// RL12 - Background byte written, pointer increments, flag set.
// RL13 - Received flag stays set until software clears.
// RL14 - Divisor is sixteen bits, high speed, fixed.
// RL15 - Receive command accepts bytes only while running.
// RL16 - Receive command times out after milliseconds.
// RL17 - Setup off disables port and releases pins.
// RL18 - Centre sampling; frames with low stop dropped.
package hsp_pkg;

    // Frame geometry: eight data bits, no parity, one stop bit.
    localparam int unsigned DATA_BITS        = 8;
    // High speed generator: one bit spans four times (divisor plus one) clocks.
    localparam int unsigned BRG_SHIFT        = 2;
    // Break length in bit times (start plus twelve low bits).
    localparam int unsigned BREAK_BITS       = 13;
    // Clock rate and one millisecond in cycles for the receive timeout.
    localparam int unsigned CLK_HZ           = 100_000_000;
    localparam int unsigned MS_IN_US         = 1000;
    localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;
    // Mode bit positions of the setup command.
    localparam int unsigned MODE_BG_BIT      = 0;
    localparam int unsigned MODE_INV_BIT     = 1;
    // Reset values.
    localparam logic [15:0] DIV_RESET        = 16'h0000;
    localparam logic [7:0]  PTR_RESET        = 8'h00;
    // Example predefined divisor, 9600 baud at a 4 MHz system clock.
    localparam logic [15:0] baud_9600_at_4mhz = 16'h0067;

    // Setup command carried as one group.
    typedef struct packed {
        logic        enable;     // Zero means the off keyword.
        logic [15:0] divisor;    // Sixteen-bit baud word.
        logic [1:0]  mode;       // Background and invert bits.
    } hsp_setup_type;

    // Transmitter states.
    typedef enum logic [1:0] {
        HSP_TX_IDLE  = 2'b00,
        HSP_TX_BREAK = 2'b01,
        HSP_TX_FRAME = 2'b10
    } hsp_tx_state_type;

endpackage : hsp_pkg

// *** design/hsp_rx_frame.sv ***
`timescale 1ns/10ps
`default_nettype none
// Receiver framer: centre sampling and stop check on a synchronised line.
module hsp_rx_frame
(
    input  wire logic        clk_in,       // System clock.
    input  wire logic        rst_n_in,     // Asynchronous reset, active low.
    input  wire logic        enable_in,    // Port enabled.
    input  wire logic [15:0] divisor_in,   // Baud word.
    input  wire logic        line_in,      // Synchronised true-polarity line.
    output logic             valid_out,    // One-cycle pulse, byte complete.
    output logic [7:0]       data_out      // Received byte.
);
    logic [17:0] tick_r;      // Baud timer.
    logic [3:0]  bit_r;       // Bit index, zero is start.
    logic        busy_r;      // Frame in progress.
    logic [7:0]  shift_r;     // Assembled data.
    logic [17:0] bit_len;     // Clocks per bit.

    // Bit length for the fixed high-speed, sixteen-bit generator.
    assign bit_len = ({2'b00, divisor_in} + 18'h00001) << hsp_pkg::BRG_SHIFT; // RL14

    // Timer restarts on the start edge; the first sample waits half a bit.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            busy_r    <= 1'b0;
            tick_r    <= 18'h00000;
            bit_r     <= 4'h0;
            shift_r   <= 8'h00;
            valid_out <= 1'b0;
            data_out  <= 8'h00;
        end
        else
        begin
            valid_out <= 1'b0;
            if (!enable_in)
            begin
                // A disabled port drops any frame in flight.
                busy_r <= 1'b0;
            end
            else if (!busy_r)
            begin
                if (!line_in)
                begin
                    busy_r <= 1'b1; // RL18
                    tick_r <= bit_len >> 1;
                    bit_r  <= 4'h0;
                end
            end
            else if (tick_r != 18'h00000)
            begin
                tick_r <= tick_r - 18'h00001;
            end
            else
            begin
                tick_r <= bit_len - 18'h00001;
                bit_r  <= bit_r + 4'h1;
                if (bit_r == 4'h0)
                begin
                    // A start glitch that is high at centre is ignored.
                    busy_r <= ~line_in;
                end
                else if (bit_r <= 4'(hsp_pkg::DATA_BITS))
                begin
                    shift_r <= {line_in, shift_r[7:1]}; // RL1
                end
                else
                begin
                    // Stop bit: only a high stop delivers the byte.
                    busy_r    <= 1'b0;
                    valid_out <= line_in; // RL18
                    data_out  <= shift_r;
                end
            end
        end
    end
endmodule : hsp_rx_frame
`default_nettype wire

// *** tb/hsp_top_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
// Port checker: ties pin, pointer and handshake outputs to their causes.
module hsp_top_chk
(
    input wire logic                   clk_in, rst_n_in, setup_in, tx_valid_in, tx_ready_out,
    input wire hsp_pkg::hsp_setup_type setup_cfg_in,
    input wire logic                   rxcmd_start_in, rxcmd_busy_out, rxcmd_done_out,
    input wire logic                   sp_we_out, flag_clr_in, rx_flag_out, tx_pin_out,
    input wire logic                   tx_pin_oe_out, pins_owned_out,
    input wire logic [7:0]             rxcmd_count_in, sp_addr_out, bg_ptr_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic en_r;  // Port switched on by the last setup.
    logic bg_r;  // Background receive chosen.
    logic inv_r; // Inverted transmit chosen.
    // Mode copy, since the checker cannot see the design's own.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            {en_r, bg_r, inv_r} <= 3'h0;
        else if (setup_in)
            {en_r, bg_r, inv_r} <= {setup_cfg_in.enable, setup_cfg_in.mode[0],
                                    setup_cfg_in.mode[1]};
    end
    property p_setup_ptr;
        setup_in |=> bg_ptr_out == 8'h00 && pins_owned_out == $past(setup_cfg_in.enable);
    endproperty
    a_setup_ptr: assert property (p_setup_ptr) else $error("setup pointer or pins");
    property p_oe;
        setup_in |=> ##1 tx_pin_oe_out == $past(setup_cfg_in.enable, 2);
    endproperty
    a_oe: assert property (p_oe) else $error("pin drive after setup");
    property p_ready;
        tx_ready_out |-> $past(tx_valid_in) ##1 !tx_ready_out;
    endproperty
    a_ready: assert property (p_ready) else $error("ready without offer");
    property p_start;
        tx_ready_out |=> tx_pin_out == inv_r;
    endproperty
    a_start: assert property (p_start) else $error("start level wrong");
    property p_bg;
        sp_we_out && bg_r |-> rx_flag_out && bg_ptr_out == sp_addr_out + 8'h01;
    endproperty
    a_bg: assert property (p_bg) else $error("background write bookkeeping");
    property p_flag;
        rx_flag_out && !flag_clr_in && !setup_in |=> rx_flag_out;
    endproperty
    a_flag: assert property (p_flag) else $error("flag dropped alone");
    property p_nobg;
        sp_we_out |-> bg_r || rxcmd_busy_out || rxcmd_done_out;
    endproperty
    a_nobg: assert property (p_nobg) else $error("write outside command");
    property p_cmd;
        rxcmd_start_in && !rxcmd_busy_out && en_r && !bg_r && rxcmd_count_in != 8'h00
            |=> rxcmd_busy_out;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command not started");
endmodule : hsp_top_chk

bind hsp_top hsp_top_chk i_hsp_top_chk (
    .clk_in, .rst_n_in, .setup_in, .setup_cfg_in, .tx_valid_in, .tx_ready_out,
    .rxcmd_start_in, .rxcmd_count_in, .rxcmd_busy_out, .rxcmd_done_out, .sp_we_out,
    .sp_addr_out, .flag_clr_in, .rx_flag_out, .bg_ptr_out, .tx_pin_out, .tx_pin_oe_out,
    .pins_owned_out);
`default_nettype wire

// *** tb/hsp_serial_dev.sv ***
`timescale 1ns/10ps
`default_nettype none
// Far serial device: frames bytes onto the receive pin, decodes the
// transmit pin. Its line idles high between frames, as a pulled-up line.
module hsp_serial_dev
#(
    parameter int unsigned BIT_CYC = 12 // Clocks per bit.
)
(
    input  wire logic  clk_in,      // System clock.
    input  wire logic  line_in,     // Port transmit pin.
    input  wire logic  invert_in,   // Port sends inverted levels.
    output logic       line_out,    // Port receive pin.
    output logic       got_out,     // Pulse, one byte decoded.
    output logic [7:0] got_data_out // Decoded byte.
);
    logic true_w; // Transmit pin in true levels.
    assign true_w = line_in ^ invert_in;
    initial line_out = 1'b1;
    // Sends one frame in true levels; a low stop bit makes a bad frame.
    task send(input logic [7:0] d, input logic stop_in);
        logic [9:0] f;
        f = {stop_in, d, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            line_out = f[i];
            repeat (BIT_CYC) @(posedge clk_in);
            #1;
        end
        line_out = 1'b1;
        repeat (BIT_CYC) @(posedge clk_in);
        #1;
    endtask : send
    // Centre sampling; the centre recheck rides out polarity-change glitches.
    initial
    begin
        {got_out, got_data_out} = 9'h000;
        forever
        begin
            @(posedge clk_in);
            if (true_w === 1'b0)
                repeat (BIT_CYC / 2) @(posedge clk_in);
            if (true_w === 1'b0)
            begin
                for (int i = 0; i < 8; i++)
                begin
                    repeat (BIT_CYC) @(posedge clk_in);
                    got_data_out[i] = true_w;
                end
                repeat (BIT_CYC) @(posedge clk_in);
                // A low stop is a break, never a byte.
                if (true_w === 1'b1)
                begin
                    #1 got_out = 1'b1;
                    @(posedge clk_in);
                    #1 got_out = 1'b0;
                end
                while (true_w !== 1'b1) @(posedge clk_in);
            end
        end
    end
endmodule : hsp_serial_dev
`default_nettype wire

// *** tb/test_hsp_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// Bench: transmit with break, background and command receive, invert, off.
module test_hsp_top;
    localparam logic [15:0] DIV = 16'h0002;          // Short baud word, fast run.
    localparam int unsigned BIT_CYC = 4 * (DIV + 1); // Clocks per bit.
    logic clk_in, rst_n_in, setup_in, tx_valid_in, tx_break_in, rxcmd_start_in;
    logic flag_clr_in, tx_ready_out, rxcmd_busy_out, rxcmd_done_out, rxcmd_tmo_out;
    logic sp_we_out, rx_flag_out, tx_pin_out, tx_pin_oe_out, pins_owned_out;
    logic rx_pin, got, inv;
    logic [7:0] tx_data_in, rxcmd_count_in, sp_addr_out, sp_data_out, bg_ptr_out;
    logic [7:0] got_data, ptr, d;
    logic [15:0] rxcmd_tmo_ms_in;
    hsp_pkg::hsp_setup_type cfg;
    logic [7:0] txq[$];  // Bytes expected on the wire.
    logic [15:0] spq[$]; // Address and data expected at the scratchpad.
    int n_fail = 0, compares = 0, n_done = 0, seed = 87415;
    hsp_top i_hsp_top (
        .clk_in, .rst_n_in, .setup_in, .setup_cfg_in(cfg), .tx_valid_in, .tx_data_in,
        .tx_break_in, .tx_ready_out, .rxcmd_start_in, .rxcmd_count_in, .rxcmd_tmo_ms_in,
        .rxcmd_busy_out, .rxcmd_done_out, .rxcmd_tmo_out, .sp_we_out, .sp_addr_out,
        .sp_data_out, .flag_clr_in, .rx_flag_out, .bg_ptr_out, .rx_pin_in(rx_pin),
        .tx_pin_out, .tx_pin_oe_out, .pins_owned_out);
    hsp_serial_dev #(.BIT_CYC(BIT_CYC)) i_hsp_serial_dev (
        .clk_in(clk_in), .line_in(tx_pin_out), .invert_in(inv), .line_out(rx_pin),
        .got_out(got), .got_data_out(got_data));
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task end_sim;
        if (n_fail == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    // Bounded wait for all noted results.
    task drain;
        int k;
        for (k = 0; k < 5000 && (txq.size() + spq.size()) > 0; k++) @(posedge clk_in);
        #1;
        if (k == 5000)
        begin
            n_fail++;
            end_sim();
        end
    endtask : drain
    // Setup, then pins, pointer and drive.
    task setup(input logic en, input logic [1:0] md);
        {setup_in, cfg, inv} = {1'b1, en, DIV, md, md[1]};
        @(posedge clk_in) #1;
        setup_in = 1'b0;
        chk("owned", pins_owned_out, en);
        chk("ptr", bg_ptr_out, 8'h00);
        @(posedge clk_in) #1;
        chk("oe", tx_pin_oe_out, en);
        ptr = 8'h00;
    endtask : setup
    // Offers a byte until taken; valid stays up for the next.
    task send_tx(input logic [7:0] dv, input logic brk);
        int k;
        k = 0;
        txq.push_back(dv);
        {tx_valid_in, tx_data_in, tx_break_in} = {1'b1, dv, brk};
        do
        begin
            @(posedge clk_in) #1;
            k++;
        end
        while (k < 4000 && tx_ready_out !== 1'b1);
        if (tx_ready_out !== 1'b1)
        begin
            n_fail++;
            end_sim();
        end
    endtask : send_tx
    // Sends a byte, notes where it lands.
    task bg_byte;
        d = 8'($random(seed));
        spq.push_back({ptr, d});
        ptr++;
        i_hsp_serial_dev.send(d, 1'b1);
    endtask : bg_byte
    always @(posedge got)
        chk("tx byte", {8'h00, got_data}, txq.size() ? {8'h00, txq.pop_front()} : 16'hFFFF);
    always @(negedge clk_in)
    begin
        if (sp_we_out === 1'b1)
            chk("sp write", {sp_addr_out, sp_data_out}, spq.size() ? spq.pop_front() : 16'hFFFF);
        if (rxcmd_tmo_out !== 1'b0)
            chk("tmo", rxcmd_tmo_out, 1'b0);
        if (rxcmd_done_out === 1'b1)
            n_done++;
    end
    initial
    begin
        {setup_in, tx_valid_in, tx_break_in, rxcmd_start_in, flag_clr_in, inv} = 6'h00;
        {tx_data_in, rxcmd_count_in, rxcmd_tmo_ms_in} = 32'h0;
        cfg = '0;
        rst_n_in = 1'b0;
        repeat (20) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        chk("idle pin", tx_pin_out, 1'b1);
        setup(1'b1, 2'b01);
        for (int i = 0; i < 4; i++)
            send_tx(8'($random(seed)), i == 0);
        tx_valid_in = 1'b0;
        drain;
        for (int i = 0; i < 3; i++)
            bg_byte();
        i_hsp_serial_dev.send(8'hA5, 1'b0);
        drain;
        chk("flag", rx_flag_out, 1'b1);
        repeat (50) @(posedge clk_in);
        #1 chk("flag kept", rx_flag_out, 1'b1);
        flag_clr_in = 1'b1;
        @(posedge clk_in);
        #1 flag_clr_in = 1'b0;
        @(posedge clk_in);
        #1 chk("flag clr", rx_flag_out, 1'b0);
        chk("ptr", bg_ptr_out, 8'h03);
        setup(1'b1, 2'b11);
        send_tx(8'($random(seed)), 1'b0);
        send_tx(8'h00, 1'b0);
        tx_valid_in = 1'b0;
        bg_byte();
        drain;
        setup(1'b1, 2'b00);
        i_hsp_serial_dev.send(8'h3C, 1'b1);
        rxcmd_count_in = 8'h02;
        rxcmd_start_in = 1'b1;
        @(posedge clk_in);
        #1 rxcmd_start_in = 1'b0;
        @(posedge clk_in);
        #1 chk("busy", rxcmd_busy_out, 1'b1);
        bg_byte();
        bg_byte();
        drain;
        chk("done", 16'(n_done), 16'h0001);
        chk("idle cmd", rxcmd_busy_out, 1'b0);
        setup(1'b0, 2'b00);
        end_sim();
    end
endmodule : test_hsp_top
`default_nettype wire
